// File: core/asrc_defines.svh
/*
  Constants of the stereo asynchronous sample rate converter core.
  Assumes inclusion by bare name from the package and the core module.
*/
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH

// Datapath widths
`define ASRC_DW 24
`define ASRC_AW 9
`define ASRC_CNT_W 16
`define ASRC_AVG_W 20
`define ASRC_ACC_W 52
// Sample buffer: depth and least lead of write over read
`define ASRC_DEPTH 512
`define ASRC_MIN_OFS 9'h010
// Fine grid: 2^20 points per input sample, coefficient span 64 taps = 2^26
`define ASRC_FRAC 20
`define ASRC_ONE 21'h100000
`define ASRC_TAPS 9'h040
`define ASRC_SPAN_BIT 26
// Longest convolution the buffer allows, (512-16) taps, and the matching least ratio
`define ASRC_MAX_TAPS 9'h1f0
`define ASRC_MIN_RATIO 21'h021085
// Rate ratio window, in input samples, and its hysteresis in output periods
`define ASRC_WIN_END 8'hff
`define ASRC_HYST 9'h002
// Period averaging: fraction bits, slow and fast shift
`define ASRC_AVG_FB 4
`define ASRC_SH_SLOW 4
`define ASRC_SH_FAST 1
// Timing resolution in femtoseconds and the clock period in picoseconds
`define ASRC_RES_FS 4960
`define ASRC_CLK_PS 4000
// Reset value and ceiling of the soft-mute gain
`define ASRC_RST_GAIN 8'h00
`define ASRC_GAIN_MAX 8'hff

`endif

// File: core/asrc_pkg.sv
/*
  Types of the sample rate converter core: stereo words, settings, states.
  Assumes asrc_defines.svh is on the include path.
*/
`include "asrc_defines.svh"

package asrc_pkg;
  typedef logic signed [`ASRC_DW-1:0] asrc_word_t;

  // ch[1] is left, ch[0] is right
  typedef struct packed {
    asrc_word_t [1:0] ch;
  } asrc_stereo_t;

  // Group delay and soft mute setting
  typedef struct packed {
    logic mute;
    logic [6:0] delay;
  } asrc_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DIV = 5'h02,
    ST_SCALE = 5'h04,
    ST_CONV = 5'h08,
    ST_DONE = 5'h10
  } asrc_state_t;
endpackage

// File: core/asrc_core.sv
/*
  Stereo asynchronous sample rate converter: input buffer, rate servo,
  phase divider and polyphase convolution engine with shared control.
  Assumes both sample strobes are one-cycle pulses synchronous to i_clk and
  that an output period is longer than one convolution.
*/
`timescale 1ns/10ps
`include "asrc_defines.svh"

// Function
// - Act as 2^20 zero-stuffed interpolator followed by low-pass filtering.
// - Each output strobe picks the nearest point on the 2^20-finer grid.
// - One convolution per output period, 64 taps when not decimating.
// - Strobe arrival found by averaging coarse period counts, not fast timing.
// - Coefficients interpolated between a small stored table of entries.
// - When decimating, scale start phase, input samples and tap count.
// - Decimating lowers cutoff by altered coefficients and longer convolution.
// - Largest decimation ratio bounded by the sample buffer depth.
// - 512-word input buffer for each of left and right.
// - Write leads read by 16 plus 7-bit delay; separate bit soft-mutes.
// - Buffer address steps down per tap, phase steps by ratio, ends on wrap.
// - Ratio held at one when upsampling, else updated beyond two-period hysteresis.
module asrc_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Input samples
  input wire logic i_in_strobe,
  input wire asrc_pkg::asrc_stereo_t i_in_sample,
  // Output sample strobe and setting
  input wire logic i_out_strobe,
  input wire asrc_pkg::asrc_cfg_t i_cfg,
  // Converted output
  output asrc_pkg::asrc_stereo_t o_out_sample,
  output logic o_out_valid,
  output logic o_settling_mute_flag
);
  import asrc_pkg::*;

  // Stored kernel entries; a triangle over 64 taps whose sum is 2^20
  function automatic logic signed [17:0] tbl(input logic [6:0] i);
    if (i <= 7'h20)
      return {1'b0, i, 10'h000};
    return {1'b0, 7'(7'h40 - i), 10'h000};
  endfunction

  // Coefficient at a fine-grid phase, linear between two stored entries
  function automatic logic signed [17:0] coef_at(input logic [26:0] ph);
    logic [6:0] i0;
    logic signed [17:0] c0;
    logic signed [17:0] c1;
    logic signed [28:0] d;
    i0 = {1'b0, ph[25:20]};
    c0 = tbl(i0);
    c1 = tbl(7'(i0 + 7'h01));
    d = (c1 - c0) * $signed({1'b0, ph[19:10]});
    return 18'(c0 + 18'(d >>> 10));
  endfunction

  // Input scaling by rate ratio and soft-mute gain
  function automatic asrc_word_t scale_in(input asrc_word_t x, input logic [20:0] r, input logic [7:0] g);
    logic signed [45:0] p1;
    logic signed [34:0] p2;
    p1 = x * $signed({1'b0, r});
    p2 = $signed(p1[45:20]) * $signed({1'b0, g});
    return p2[31:8];
  endfunction

  // Output truncation to the word width with saturation
  function automatic asrc_word_t sat_out(input logic signed [`ASRC_ACC_W-1:0] a);
    logic signed [31:0] s;
    s = $signed(a[51:20]);
    if (s > 32'sh007fffff)
      return 24'sh7fffff;
    if (s < -32'sh00800000)
      return 24'sh800000;
    return s[23:0];
  endfunction

  // Servo and buffer-write state
  logic [`ASRC_CNT_W-1:0] since_q, since_d;
  logic [`ASRC_AVG_W-1:0] avg_q, avg_d;
  logic [7:0] win_q, win_d;
  logic [8:0] ocnt_q, ocnt_d, prev_q, prev_d;
  logic [20:0] ratio_q, ratio_d;
  logic settle_q, settle_d;
  logic [`ASRC_AW-1:0] wr_q, wr_d;
  logic [7:0] gain_q, gain_d;
  logic signed [20:0] diff;
  logic [8:0] odist;
  // Convolution state
  asrc_state_t state_q, state_d;
  logic [4:0] dcnt_q, dcnt_d;
  logic [20:0] rem_q, rem_d, q_q, q_d, step_q, step_d;
  logic [`ASRC_AVG_W-1:0] dv_q, dv_d, mark;
  logic [21:0] r2;
  logic [41:0] pscale;
  logic [26:0] ph_q, ph_d, nph;
  logic [`ASRC_AW-1:0] rd_q, rd_d;
  logic [8:0] taps_q, taps_d;
  logic signed [`ASRC_ACC_W-1:0] acc_q [2];
  logic signed [`ASRC_ACC_W-1:0] acc_d [2];
  logic signed [`ASRC_ACC_W-1:0] prod [2];
  logic signed [17:0] coef;
  asrc_stereo_t res_q, res_d, out_q, out_d;
  logic have_q, have_d, valid_q, valid_d;

  assign coef = coef_at(ph_q);

  // One buffer and one multiplier per channel; read is asynchronous from the array
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [`ASRC_DW-1:0] mem [`ASRC_DEPTH];
    always_ff @(posedge i_clk) begin
      if (i_in_strobe)
        mem[wr_q] <= scale_in(i_in_sample.ch[c], ratio_q, gain_q);
    end
    assign prod[c] = mem[rd_q] * coef;
  end

  // Rate servo: period averaging, ratio window with hysteresis, soft mute
  assign diff = $signed({1'b0, since_q + 16'h0001, 4'h0}) - $signed({1'b0, avg_q});
  assign odist = (ocnt_q > prev_q) ? 9'(ocnt_q - prev_q) : 9'(prev_q - ocnt_q);
  always_comb begin
    since_d = since_q;
    avg_d = avg_q;
    win_d = win_q;
    ocnt_d = ocnt_q;
    prev_d = prev_q;
    ratio_d = ratio_q;
    settle_d = settle_q;
    wr_d = wr_q;
    gain_d = gain_q;
    if (since_q != 16'hffff)
      since_d = 16'(since_q + 16'h0001);
    if (i_out_strobe && ocnt_q != 9'h1ff)
      ocnt_d = 9'(ocnt_q + 9'h001);
    if (i_in_strobe) begin
      since_d = '0;
      wr_d = 9'(wr_q + 9'h001);
      win_d = 8'(win_q + 8'h01);
      // Fast settling while unsettled; slow averaging rejects strobe jitter
      if (settle_q)
        avg_d = 20'(avg_q + 20'(diff >>> `ASRC_SH_FAST));
      else
        avg_d = 20'(avg_q + 20'(diff >>> `ASRC_SH_SLOW));
      if (i_cfg.mute && gain_q != 8'h00)
        gain_d = 8'(gain_q - 8'h01);
      else if (!i_cfg.mute && gain_q != `ASRC_GAIN_MAX)
        gain_d = 8'(gain_q + 8'h01);
      if (win_q == `ASRC_WIN_END) begin
        ocnt_d = '0;
        prev_d = ocnt_q;
        if (ocnt_q[8]) begin
          ratio_d = `ASRC_ONE;
          settle_d = (ratio_q != `ASRC_ONE);
        end else if (odist > `ASRC_HYST) begin
          // Ratio floor keeps the convolution inside the buffer
          ratio_d = ({1'b0, ocnt_q[7:0], 12'h000} < `ASRC_MIN_RATIO) ?
                    `ASRC_MIN_RATIO : {1'b0, ocnt_q[7:0], 12'h000};
          settle_d = 1'b1;
        end else begin
          prev_d = prev_q;
          settle_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      since_q <= '0;
      avg_q <= '0;
      win_q <= '0;
      ocnt_q <= '0;
      prev_q <= '0;
      ratio_q <= `ASRC_ONE;
      settle_q <= 1'b1;
      wr_q <= '0;
      gain_q <= `ASRC_RST_GAIN;
    end else begin
      since_q <= since_d;
      avg_q <= avg_d;
      win_q <= win_d;
      ocnt_q <= ocnt_d;
      prev_q <= prev_d;
      ratio_q <= ratio_d;
      settle_q <= settle_d;
      wr_q <= wr_d;
      gain_q <= gain_d;
    end
  end

  // Convolution control: divide for the fine phase, scale it, then run the taps
  assign mark = ({since_q, 4'h0} >= avg_q) ? 20'(avg_q - 20'h00001) : {since_q, 4'h0};
  assign r2 = {rem_q, 1'b0};
  assign pscale = q_q * step_q;
  assign nph = 27'(ph_q + {6'h00, step_q});
  always_comb begin
    state_d = state_q;
    dcnt_d = dcnt_q;
    rem_d = rem_q;
    q_d = q_q;
    dv_d = dv_q;
    step_d = step_q;
    ph_d = ph_q;
    rd_d = rd_q;
    taps_d = taps_q;
    res_d = res_q;
    have_d = have_q;
    out_d = out_q;
    valid_d = 1'b0;
    for (int c = 0; c < 2; c++)
      acc_d[c] = acc_q[c];
    // Last period's result goes out on the strobe itself
    if (i_out_strobe) begin
      out_d = res_q;
      valid_d = have_q;
    end
    case (state_q)
      ST_IDLE: begin
        // A strobe arriving mid-convolution is not started, so one run per period
        if (i_out_strobe) begin
          state_d = ST_DIV;
          rem_d = {1'b0, mark};
          dv_d = avg_q;
          q_d = '0;
          dcnt_d = '0;
          step_d = ratio_q;
          rd_d = 9'(wr_q - `ASRC_MIN_OFS - {2'h0, i_cfg.delay});
          taps_d = '0;
          for (int c = 0; c < 2; c++)
            acc_d[c] = '0;
        end
      end
      ST_DIV: begin
        dcnt_d = 5'(dcnt_q + 5'h01);
        if (dcnt_q == 5'h14) begin
          q_d = 21'(q_q + {20'h00000, (r2 >= {2'h0, dv_q})});
          state_d = ST_SCALE;
        end else if (r2 >= {2'h0, dv_q}) begin
          rem_d = 21'(r2 - {2'h0, dv_q});
          q_d = {q_q[19:0], 1'b1};
        end else begin
          rem_d = r2[20:0];
          q_d = {q_q[19:0], 1'b0};
        end
      end
      ST_SCALE: begin
        ph_d = {6'h00, pscale[40:20]};
        state_d = ST_CONV;
      end
      ST_CONV: begin
        for (int c = 0; c < 2; c++)
          acc_d[c] = acc_q[c] + prod[c];
        rd_d = 9'(rd_q - 9'h001);
        taps_d = 9'(taps_q + 9'h001);
        ph_d = nph;
        if (nph[`ASRC_SPAN_BIT])
          state_d = ST_DONE;
      end
      ST_DONE: begin
        for (int c = 0; c < 2; c++)
          res_d.ch[c] = sat_out(acc_q[c]);
        have_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      dcnt_q <= '0;
      rem_q <= '0;
      q_q <= '0;
      dv_q <= '0;
      step_q <= `ASRC_ONE;
      ph_q <= '0;
      rd_q <= '0;
      taps_q <= '0;
      res_q <= '0;
      have_q <= 1'b0;
      out_q <= '0;
      valid_q <= 1'b0;
      for (int c = 0; c < 2; c++)
        acc_q[c] <= '0;
    end else begin
      state_q <= state_d;
      dcnt_q <= dcnt_d;
      rem_q <= rem_d;
      q_q <= q_d;
      dv_q <= dv_d;
      step_q <= step_d;
      ph_q <= ph_d;
      rd_q <= rd_d;
      taps_q <= taps_d;
      res_q <= res_d;
      have_q <= have_d;
      out_q <= out_d;
      valid_q <= valid_d;
      for (int c = 0; c < 2; c++)
        acc_q[c] <= acc_d[c];
    end
  end

  assign o_out_sample = out_q;
  assign o_out_valid = valid_q;
  assign o_settling_mute_flag = settle_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_conv_start: assert property ((state_q == ST_IDLE && i_out_strobe) |=> state_q == ST_DIV)
    else $error("convolution not started on output strobe");
  a_div_length: assert property ((state_q == ST_IDLE && i_out_strobe) |-> ##22 state_q == ST_SCALE)
    else $error("phase divide did not take 21 cycles");
  a_frac_range: assert property (state_q == ST_SCALE |-> q_q <= `ASRC_ONE)
    else $error("fine phase beyond one input period");
  a_start_scaled: assert property (state_q == ST_SCALE |=> ph_q <= {6'h00, step_q})
    else $error("start phase not scaled by ratio");
  a_read_lead: assert property ((state_q == ST_IDLE && i_out_strobe) |=>
      rd_q == 9'($past(wr_q) - `ASRC_MIN_OFS - {2'h0, $past(i_cfg.delay)}))
    else $error("read start not 16 plus delay behind write");
  a_addr_step: assert property (state_q == ST_CONV |=> rd_q == 9'($past(rd_q) - 9'h001))
    else $error("buffer address did not step down by one");
  a_tap_bound: assert property (state_q == ST_DONE |-> taps_q <= `ASRC_MAX_TAPS)
    else $error("convolution longer than buffer allows");
  a_taps_unity: assert property ((state_q == ST_DONE && step_q == `ASRC_ONE) |->
      (taps_q == `ASRC_TAPS || taps_q == 9'(`ASRC_TAPS - 9'h001)))
    else $error("non-decimating convolution not 64 taps");
  a_ratio_range: assert property (ratio_q <= `ASRC_ONE && ratio_q >= `ASRC_MIN_RATIO)
    else $error("rate ratio out of range");
  a_mute_ramp: assert property ((i_in_strobe && i_cfg.mute && gain_q != 8'h00) |=>
      gain_q == 8'($past(gain_q) - 8'h01))
    else $error("soft mute gain did not ramp down");
  a_valid_align: assert property (o_out_valid |-> $past(i_out_strobe) && $past(have_q))
    else $error("output valid not aligned to strobe");
endmodule

// File: verif/asrc_stream_model.sv
/*
  Far-side model: an audio source pacing input samples and a sink pacing output strobes.
  Assumes i_clk is the core clock and both periods are at least two cycles.
*/
`timescale 1ns/10ps

module asrc_stream_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pacing and content
  input wire logic [15:0] i_in_period,
  input wire logic [15:0] i_out_period,
  input wire asrc_pkg::asrc_stereo_t i_level,
  // Streams toward the core
  output asrc_pkg::asrc_stereo_t o_in_sample,
  output logic o_in_strobe,
  output logic o_out_strobe
);
  import asrc_pkg::*;
  logic [15:0] in_cnt_q;
  logic [15:0] out_cnt_q;

  // Falling-edge launch keeps strobes half a cycle clear of the sampling edge
  always @(negedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_cnt_q <= 16'h0001;
      out_cnt_q <= 16'h0003;
      o_in_strobe <= 1'b0;
      o_out_strobe <= 1'b0;
      o_in_sample <= '0;
    end else begin
      in_cnt_q <= (in_cnt_q >= i_in_period - 16'h0001) ? 16'h0000 : in_cnt_q + 16'h0001;
      out_cnt_q <= (out_cnt_q >= i_out_period - 16'h0001) ? 16'h0000 : out_cnt_q + 16'h0001;
      o_in_strobe <= (in_cnt_q == 16'h0000);
      o_out_strobe <= (out_cnt_q == 16'h0000);
      // Data is only meaningful with the strobe, so it toggles to junk in between
      o_in_sample <= (in_cnt_q == 16'h0000) ? i_level : ~o_in_sample;
    end
  end
endmodule

// File: verif/testbench.sv
/*
  Self-checking bench for the sample rate converter: upsampling, decimation, mute.
  Assumes the core and its package are compiled first.
*/
`timescale 1ns/10ps

module testbench;
  import asrc_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [15:0] in_period = 16'h0064;
  logic [15:0] out_period = 16'h0060;
  asrc_cfg_t cfg = '0;
  asrc_stereo_t level = {24'h100000, 24'hf80000};
  asrc_stereo_t in_sample;
  asrc_stereo_t out_sample;
  logic in_strobe;
  logic out_strobe;
  logic out_valid;
  logic settle_flag;
  int miscompares = 0;
  int n_compared = 0;

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  asrc_stream_model asrc_stream_model_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_in_period(in_period),
    .i_out_period(out_period), .i_level(level), .o_in_sample(in_sample), .o_in_strobe(in_strobe),
    .o_out_strobe(out_strobe));

  asrc_core asrc_core_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_in_strobe(in_strobe),
    .i_in_sample(in_sample), .i_out_strobe(out_strobe), .i_cfg(cfg), .o_out_sample(out_sample),
    .o_out_valid(out_valid), .o_settling_mute_flag(settle_flag));

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] expd);
    n_compared++;
    if (seen !== expd) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, expd, seen);
    end
  endtask

  // Unknown words give an unknown result, which never matches 1
  function automatic logic near(input asrc_word_t seen, input asrc_word_t expd, input asrc_word_t tol);
    near = (seen > expd - tol) && (seen < expd + tol);
  endfunction

  task automatic wait_inputs(input int n);
    repeat (n) @(posedge i_clk iff in_strobe);
  endtask

  // Bounded wait for the settling flag to reach a level
  task automatic wait_flag(input logic lvl, input int limit);
    for (int i = 0; i < limit && settle_flag !== lvl; i++) @(negedge i_clk);
  endtask

  // Valid must follow the output strobe by one edge and last one cycle
  task automatic check_pulse(input asrc_word_t tol);
    @(posedge i_clk iff out_strobe);
    @(negedge i_clk);
    check("valid high", out_valid, 1'b1);
    check("left level", near(out_sample.ch[1], 24'h0ff000, tol), 1'b1);
    check("right level", near(out_sample.ch[0], 24'hf80800, tol), 1'b1);
    @(negedge i_clk);
    check("valid low", out_valid, 1'b0);
  endtask

  task automatic test_reset();
    repeat (6) @(negedge i_clk);
    check("reset sample", out_sample, 48'h0);
    check("reset valid", out_valid, 1'b0);
    check("reset flag", settle_flag, 1'b1);
    i_arst_n = 1'b1;
    @(negedge i_clk);
    check("release flag", settle_flag, 1'b1);
    check("release valid", out_valid, 1'b0);
    $display("test_reset done");
  endtask

  // Output rate above input rate: ratio stays one, 64 taps, unity DC gain after unmute.
  // The read window reaches 24 to 87 words behind the write pointer, and the first 255 words
  // are still on the unmute ramp, so wait until the window holds full-gain words only.
  task automatic test_upsample();
    cfg.delay = 7'h08;
    wait_inputs(360);
    @(negedge i_clk);
    check("flag at unity", settle_flag, 1'b0);
    check_pulse(24'h008000);
    check_pulse(24'h008000);
    $display("test_upsample done");
  endtask

  // Input far faster: ratio changes, servo settles, DC gain stays near one
  task automatic test_decimate();
    @(negedge i_clk);
    cfg.delay = 7'h00;
    in_period = 16'h0019;
    out_period = 16'h0258;
    wait_flag(1'b1, 20000);
    check("flag on ratio change", settle_flag, 1'b1);
    wait_flag(1'b0, 20000);
    check("flag after settling", settle_flag, 1'b0);
    wait_inputs(520);
    check_pulse(24'h010000);
    $display("test_decimate done");
  endtask

  // Mute ramps the stored words to zero, so the whole window reads silence
  task automatic test_mute();
    @(negedge i_clk);
    cfg.mute = 1'b1;
    wait_inputs(800);
    @(posedge i_clk iff out_strobe);
    @(negedge i_clk);
    check("muted valid", out_valid, 1'b1);
    check("muted sample", out_sample, 48'h0);
    $display("test_mute done");
  endtask

  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected run is near 88000 cycles; this leaves room and keeps a hang under 100000 cycles
  initial begin
    repeat (96000) @(posedge i_clk);
    miscompares++;
    $display("ERROR watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    test_reset();
    test_upsample();
    test_decimate();
    test_mute();
    print_verdict();
  end
endmodule
